/* verilog/sblcf_defines.svh */
// Offsets, field positions, reset values and timing counts of the
// cycle-timer, channel filter and queue-control register slice.
// Assumes a 32-bit APB with byte addresses.
`ifndef SBLCF_DEFINES_SVH
`define SBLCF_DEFINES_SVH
`define SBLCF_OFF_CTRL     8'h08
`define SBLCF_OFF_MASK     8'h0C
`define SBLCF_OFF_FLAGS    8'h10
`define SBLCF_OFF_TIMER    8'h14
`define SBLCF_OFF_ISO      8'h18
`define SBLCF_OFF_QCTL     8'h1C
`define SBLCF_RST_WORD     32'h0000_0000
`define SBLCF_CTL_TMR_EN   0
`define SBLCF_CTL_MASTER   1
`define SBLCF_CTL_SOURCE   2
`define SBLCF_CTL_ALL_ISO  3
`define SBLCF_CTL_BLK_EN   4
`define SBLCF_CTL_BAD_FL   5
`define SBLCF_CTL_BITS     6
`define SBLCF_FL_BLKRDY    6
`define SBLCF_FL_SEC       20
`define SBLCF_FL_BEGIN     21
`define SBLCF_FL_END       22
`define SBLCF_FL_PEND      23
`define SBLCF_FL_MISS      24
`define SBLCF_FL_CARB      25
`define SBLCF_FL_IARB      31
`define SBLCF_FL_USED      32'h83F0_0040
`define SBLCF_TM_SEC_LSB   0
`define SBLCF_TM_CYC_LSB   7
`define SBLCF_TM_OFF_LSB   20
`define SBLCF_ISO_FIRST_PORT_TAG     0
`define SBLCF_ISO_CH1      2
`define SBLCF_ISO_SECOND_PORT_TAG     8
`define SBLCF_ISO_CH2      10
`define SBLCF_ISO_P1_EN    16
`define SBLCF_ISO_P2_EN    17
`define SBLCF_ISO_TAG_EN   31
`define SBLCF_ISO_USED     32'h8003_FFFF
`define SBLCF_QC_TRIG_LSB  5
`define SBLCF_QC_ATSZ_LSB  14
`define SBLCF_QC_ITSZ_LSB  23
`define SBLCF_OFF_TERM     12'hBFF
`define SBLCF_CYC_LAST     13'h1F3F
`define SBLCF_QBUF_QUADS   10'h200
`endif

/* verilog/sblcf_pkg.sv */
// Types of the cycle-timer, channel filter and queue-control slice.
// Assumes sblcf_defines.svh for offsets, field positions and reset values; field widths are set here.
package sblcf_pkg;
  typedef enum logic [0:0] {
    SBLCF_IDLE = 1'b0,
    SBLCF_RUN  = 1'b1
  } sblcf_phase_t;
  typedef struct packed {
    logic start_sent;
    logic start_rcvd;
    logic sub_gap;
    logic cyc_arb_fail;
    logic iso_arb_fail;
    logic source_tick;
  } sblcf_link_ev_t;
  typedef struct packed {
    logic       valid;
    logic [5:0] channel;
    logic [1:0] tag;
  } sblcf_iso_hdr_t;
  typedef struct packed {
    logic quadlet;
    logic packet_end;
  } sblcf_rx_ev_t;
  typedef struct packed {
    logic flush_async_tx_queue;
    logic flush_iso_tx_queue;
    logic flush_rx_queue;
  } sblcf_flush_t;
  typedef struct packed {
    logic [8:0] async_tx_queue_depth;
    logic [8:0] iso_tx_queue_depth;
    logic [9:0] rx_queue_depth;
    logic [8:0] trigger_size;
  } sblcf_sizes_t;
  typedef struct packed {
    logic [5:0]   ctrl;
    logic [31:0]  mask;
    logic [31:0]  flags;
    logic [11:0]  offset;
    logic [12:0]  cycles;
    logic [6:0]   secs;
    logic [31:0]  iso;
    logic [8:0]   trig;
    logic [8:0]   atsz;
    logic [8:0]   itsz;
    logic [9:0]   rxdepth;
    sblcf_flush_t flush;
    logic         pending;
    sblcf_phase_t phase;
    logic [1:0]   rolls;
    logic [8:0]   qcnt;
    logic         accept;
    logic         blkrdy;
    logic         irq;
    logic [31:0]  rdata;
  } sblcf_state_t;
endpackage

/* verilog/sblcf_regs.sv */
// Cycle event flags, cycle timer, iso channel filter and queue control,
// reached over a zero-wait APB slave.
// Assumes link-layer event pulses and iso headers synchronous to sys_clk.
// Summary of operation
// R1 - Seconds field increment sets the second-tick event flag.
// R2 - Cycle-start packet sent or received sets the cycle-begin flag.
// R3 - Subaction gap after a cycle start sets the cycle-end flag.
// R4 - Offset reaching zero raises awaiting flag until the cycle ends.
// R5 - Non-master: two rollovers without received start set cycle-missing.
// R6 - Lost arbitration for cycle start sets its loss flag.
// R7 - Lost arbitration for an iso packet sets its loss flag.
// R8 - Timer word: seconds low, cycle count middle, offset high.
// R9 - Source and enable steer the writable, zero-reset timer; master only affects R5.
// R10 - Accept-all setting passes every iso channel, ignoring the filter.
// R11 - First port enabled accepts packets matching its channel field.
// R12 - Second port enabled accepts packets matching its channel field.
// R13 - Tag compare on: tag and channel of one port must both match.
// R14 - Writing one to a flush bit empties that queue; bit self-clears.
// R15 - Trigger size splits received packets unless disabled or flushing.
// R16 - Async transmit size allocates quadlets, software keeps limits.
// R17 - Iso transmit size allocates quadlets under the same limits.
// R18 - Receive queue gets 512 minus both transmit allocations.
// R19 - Block-ready marks a trigger block or whole packet accepted.
// R20 - Event flags stay until cleared; mask gates them to interrupt.
// R21 - Offset wraps into cycle count; cycle count wraps at 8000.
`timescale 1ns/1ps
`include "sblcf_defines.svh"
module sblcf_regs (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire sblcf_pkg::sblcf_link_ev_t link_ev,
  input  wire sblcf_pkg::sblcf_iso_hdr_t iso_hdr,
  input  wire sblcf_pkg::sblcf_rx_ev_t   rx_ev,
  output logic                       iso_accept,
  output logic                       receive_block_ready,
  output sblcf_pkg::sblcf_flush_t    flush,
  output sblcf_pkg::sblcf_sizes_t    sizes,
  output logic      [31:0]           cycle_time,
  output logic                       irq
);
  import sblcf_pkg::*;

  logic         rst_s1;
  logic         rst_n;
  sblcf_state_t st_reg;
  sblcf_state_t st_next;
  logic         hit;
  logic         wr;
  logic [31:0]  wmask;
  logic [31:0]  rflags;
  logic [31:0]  rmux;
  logic         roll;
  logic         start_any;
  logic         done_ev;
  logic         trig_on;
  logic [8:0]   qinc;
  logic         m1;
  logic         m2;
  logic [9:0]   tx_sum;
  logic [31:0]  set_fl;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  always_comb
  begin
    st_next   = st_reg;
    hit       = (paddr == `SBLCF_OFF_CTRL) || (paddr == `SBLCF_OFF_MASK) ||
                (paddr == `SBLCF_OFF_FLAGS) || (paddr == `SBLCF_OFF_TIMER) ||
                (paddr == `SBLCF_OFF_ISO) || (paddr == `SBLCF_OFF_QCTL);
    wr        = psel && penable && pwrite && hit;
    wmask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    rflags    = st_reg.flags;
    rflags[`SBLCF_FL_PEND] = st_reg.pending;
    set_fl    = 32'h0000_0000;
    // Read data captured in the setup phase
    rmux = 32'h0000_0000;
    unique case (paddr)
      `SBLCF_OFF_CTRL:  rmux = {26'h0, st_reg.ctrl};
      `SBLCF_OFF_MASK:  rmux = st_reg.mask;
      `SBLCF_OFF_FLAGS: rmux = rflags;
      `SBLCF_OFF_TIMER: rmux = {st_reg.offset, st_reg.cycles,
                                st_reg.secs}; // R8
      `SBLCF_OFF_ISO:   rmux = st_reg.iso;
      `SBLCF_OFF_QCTL:  rmux = {st_reg.itsz, st_reg.atsz, st_reg.trig,
                                5'h00}; // R14
      default:          rmux = 32'h0000_0000;
    endcase
    if (psel && !penable)
      st_next.rdata = rmux;

    // Cycle timer
    roll = 1'b0;
    if (st_reg.ctrl[`SBLCF_CTL_TMR_EN]) // R9
    begin
      if (st_reg.ctrl[`SBLCF_CTL_SOURCE])
        roll = link_ev.source_tick; // R9
      else
        roll = (st_reg.offset == `SBLCF_OFF_TERM); // R21
      st_next.offset = roll ? 12'h000 : 12'(st_reg.offset + 12'h001);
      if (roll)
      begin
        set_fl[`SBLCF_FL_PEND] = 1'b1; // R4
        if (st_reg.cycles == `SBLCF_CYC_LAST) // R21
        begin
          st_next.cycles = 13'h0000;
          st_next.secs   = 7'(st_reg.secs + 7'h01);
          set_fl[`SBLCF_FL_SEC] = 1'b1; // R1
        end
        else
          st_next.cycles = 13'(st_reg.cycles + 13'h0001);
      end
    end
    if (wr && paddr == `SBLCF_OFF_TIMER) // R9
    begin
      st_next.offset = (st_reg.offset & ~wmask[31:20]) |
                       (pwdata[31:20] & wmask[31:20]);
      st_next.cycles = (st_reg.cycles & ~wmask[19:7]) |
                       (pwdata[19:7] & wmask[19:7]);
      st_next.secs   = (st_reg.secs & ~wmask[6:0]) |
                       (pwdata[6:0] & wmask[6:0]);
      if (st_next.offset == 12'h000)
        set_fl[`SBLCF_FL_PEND] = 1'b1; // R4
    end

    // Cycle phase and loss tracking
    start_any = link_ev.start_sent || link_ev.start_rcvd;
    done_ev   = (st_reg.phase == SBLCF_RUN) && link_ev.sub_gap && !start_any;
    if (start_any)
    begin
      st_next.phase = SBLCF_RUN;
      set_fl[`SBLCF_FL_BEGIN] = 1'b1; // R2
    end
    else if (done_ev)
    begin
      st_next.phase = SBLCF_IDLE;
      set_fl[`SBLCF_FL_END] = 1'b1; // R3
    end
    if (set_fl[`SBLCF_FL_PEND])
      st_next.pending = 1'b1; // R4
    else if (done_ev)
      st_next.pending = 1'b0; // R4
    if (st_reg.ctrl[`SBLCF_CTL_MASTER] || link_ev.start_rcvd)
      st_next.rolls = 2'h0; // R5
    else if (roll && st_reg.rolls == 2'h1)
    begin
      st_next.rolls = 2'h0;
      set_fl[`SBLCF_FL_MISS] = 1'b1; // R5
    end
    else if (roll)
      st_next.rolls = 2'h1;
    set_fl[`SBLCF_FL_CARB] = link_ev.cyc_arb_fail; // R6
    set_fl[`SBLCF_FL_IARB] = link_ev.iso_arb_fail; // R7

    // Iso channel filter
    m1 = st_reg.iso[`SBLCF_ISO_P1_EN] &&
         iso_hdr.channel == st_reg.iso[`SBLCF_ISO_CH1 +: 6] &&
         (!st_reg.iso[`SBLCF_ISO_TAG_EN] ||
          iso_hdr.tag == st_reg.iso[`SBLCF_ISO_FIRST_PORT_TAG +: 2]); // R11 R13
    m2 = st_reg.iso[`SBLCF_ISO_P2_EN] &&
         iso_hdr.channel == st_reg.iso[`SBLCF_ISO_CH2 +: 6] &&
         (!st_reg.iso[`SBLCF_ISO_TAG_EN] ||
          iso_hdr.tag == st_reg.iso[`SBLCF_ISO_SECOND_PORT_TAG +: 2]); // R12 R13
    st_next.accept = iso_hdr.valid &&
                     (st_reg.ctrl[`SBLCF_CTL_ALL_ISO] || m1 || m2); // R10

    // Receive block counting
    trig_on = st_reg.ctrl[`SBLCF_CTL_BLK_EN] &&
              !st_reg.ctrl[`SBLCF_CTL_BAD_FL] &&
              st_reg.trig != 9'h000; // R15
    qinc = rx_ev.quadlet ? 9'(st_reg.qcnt + 9'h001) : st_reg.qcnt;
    st_next.blkrdy = 1'b0;
    st_next.qcnt   = qinc;
    if (trig_on && rx_ev.quadlet && qinc == st_reg.trig)
    begin
      st_next.blkrdy = 1'b1; // R19
      st_next.qcnt   = 9'h000;
    end
    else if (rx_ev.packet_end)
    begin
      st_next.blkrdy = !trig_on || qinc != 9'h000; // R19
      st_next.qcnt   = 9'h000;
    end
    if (st_next.blkrdy)
      set_fl[`SBLCF_FL_BLKRDY] = 1'b1; // R19

    // Flush pulses last one cycle
    st_next.flush = '0; // R14
    if (wr && paddr == `SBLCF_OFF_QCTL)
    begin
      st_next.flush = {pwdata[0] & wmask[0], pwdata[1] & wmask[1],
                       pwdata[2] & wmask[2]}; // R14
      st_next.trig  = (st_reg.trig & ~wmask[13:5]) |
                      (pwdata[13:5] & wmask[13:5]); // R15
      st_next.atsz  = (st_reg.atsz & ~wmask[22:14]) |
                      (pwdata[22:14] & wmask[22:14]); // R16
      st_next.itsz  = (st_reg.itsz & ~wmask[31:23]) |
                      (pwdata[31:23] & wmask[31:23]); // R17
      if (pwdata[2] && wmask[2])
        st_next.qcnt = 9'h000;
    end
    tx_sum = {1'b0, st_reg.atsz} + {1'b0, st_reg.itsz};
    st_next.rxdepth = (tx_sum > `SBLCF_QBUF_QUADS) ? 10'h000 :
                      10'(`SBLCF_QBUF_QUADS - tx_sum); // R18

    // Other software registers
    if (wr && paddr == `SBLCF_OFF_CTRL)
      st_next.ctrl = (st_reg.ctrl & ~wmask[5:0]) | (pwdata[5:0] & wmask[5:0]);
    if (wr && paddr == `SBLCF_OFF_MASK)
      st_next.mask = ((st_reg.mask & ~wmask) | (pwdata & wmask)) &
                     `SBLCF_FL_USED;
    if (wr && paddr == `SBLCF_OFF_ISO)
      st_next.iso = ((st_reg.iso & ~wmask) | (pwdata & wmask)) &
                    `SBLCF_ISO_USED;

    // Sticky flags, set wins over write-one clear
    if (wr && paddr == `SBLCF_OFF_FLAGS)
      st_next.flags = st_reg.flags & ~(pwdata & wmask); // R20
    st_next.flags = (st_next.flags | set_fl) & `SBLCF_FL_USED; // R20
    st_next.flags[`SBLCF_FL_PEND] = 1'b0;
    st_next.irq = |(rflags & st_reg.mask); // R20
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg         <= '0;
      st_reg.phase   <= SBLCF_IDLE;
      st_reg.rxdepth <= `SBLCF_QBUF_QUADS; // R18
    end
    else
      st_reg <= st_next;
  end

  assign prdata              = st_reg.rdata;
  assign pready              = psel && penable;
  assign pslverr             = psel && penable && !hit;
  assign iso_accept          = st_reg.accept;
  assign receive_block_ready = st_reg.blkrdy;
  assign flush               = st_reg.flush;
  assign sizes               = {st_reg.atsz, st_reg.itsz, st_reg.rxdepth,
                                st_reg.trig};
  assign cycle_time          = {st_reg.offset, st_reg.cycles, st_reg.secs};
  assign irq                 = st_reg.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_second_roll;
    roll && st_reg.rolls == 2'h1 && !st_reg.ctrl[`SBLCF_CTL_MASTER] &&
    !link_ev.start_rcvd;
  endsequence
  sequence s_cycle_close;
    st_reg.phase == SBLCF_RUN ##0 link_ev.sub_gap && !start_any;
  endsequence

  chk_sec_event: assert property ( // R1
    roll && st_reg.cycles == `SBLCF_CYC_LAST &&
    !(wr && paddr == `SBLCF_OFF_TIMER) |=>
    st_reg.flags[`SBLCF_FL_SEC] && st_reg.cycles == 13'h0000)
    else $error("second tick flag or cycle wrap missing");
  chk_begin_flag: assert property ( // R2
    start_any |=> st_reg.flags[`SBLCF_FL_BEGIN] && st_reg.phase == SBLCF_RUN)
    else $error("cycle begin flag not set");
  chk_cycle_close: assert property ( // R3
    s_cycle_close |=> st_reg.flags[`SBLCF_FL_END] &&
    st_reg.phase == SBLCF_IDLE && !st_reg.pending)
    else $error("cycle end not flagged");
  chk_pending_hold: assert property ( // R4
    st_reg.pending && !done_ev |=> st_reg.pending)
    else $error("awaiting flag dropped early");
  chk_cycle_missing: assert property ( // R5
    s_second_roll |=> st_reg.flags[`SBLCF_FL_MISS])
    else $error("cycle missing flag not set");
  chk_arb_loss: assert property ( // R6
    link_ev.cyc_arb_fail |=> st_reg.flags[`SBLCF_FL_CARB] ##1
    (st_reg.flags[`SBLCF_FL_CARB] || $past(wr)))
    else $error("cycle start arbitration loss lost");
  chk_iso_loss: assert property ( // R7
    link_ev.iso_arb_fail |=> st_reg.flags[`SBLCF_FL_IARB])
    else $error("iso arbitration loss lost");
  chk_offset_wrap: assert property ( // R21
    st_reg.ctrl == 6'h01 && st_reg.offset == `SBLCF_OFF_TERM &&
    !wr |=> st_reg.offset == 12'h000 && $changed(st_reg.cycles))
    else $error("offset did not wrap into cycle count");
  chk_accept_all: assert property ( // R10
    iso_hdr.valid && st_reg.ctrl[`SBLCF_CTL_ALL_ISO] |=> iso_accept)
    else $error("accept all did not pass packet");
  chk_flush_pulse: assert property ( // R14
    flush != 3'h0 |=> flush == 3'h0)
    else $error("flush pulse longer than one cycle");
  chk_rx_depth: assert property ( // R18
    $stable(st_reg.atsz) && $stable(st_reg.itsz) &&
    ({1'b0, st_reg.atsz} + {1'b0, st_reg.itsz} <= `SBLCF_QBUF_QUADS) |->
    st_reg.rxdepth + {1'b0, st_reg.atsz} + {1'b0, st_reg.itsz} ==
    `SBLCF_QBUF_QUADS)
    else $error("receive depth not the remainder");
  chk_irq_gate: assert property ( // R20
    (st_reg.flags & st_reg.mask) != 32'h0000_0000 |=> irq)
    else $error("enabled flag did not raise interrupt");
  chk_irq_quiet: assert property ( // R20
    st_reg.mask == 32'h0000_0000 |=> !irq)
    else $error("interrupt raised with every flag masked");
endmodule // sblcf_regs

/* testbench/tb_sblcf_regs.sv */
// Self-checking bench for the cycle timer, iso filter and queue control.
// Assumes a zero-wait APB slave and link events as one-cycle pulses.
`timescale 1ns/1ps
`include "sblcf_defines.svh"
module tb_sblcf_regs;
  import sblcf_pkg::*;
  logic           sys_clk;
  logic           resetn;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [7:0]     paddr;
  logic [31:0]    pwdata;
  logic [3:0]     pstrb;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  sblcf_link_ev_t link_ev;
  sblcf_iso_hdr_t iso_hdr;
  sblcf_rx_ev_t   rx_ev;
  logic           iso_accept;
  logic           receive_block_ready;
  sblcf_flush_t   flush;
  sblcf_sizes_t   sizes;
  logic [31:0]    cycle_time;
  logic           irq;
  logic [31:0]    rd;
  logic [31:0]    v;
  logic [31:0]    iso_m;
  logic [31:0]    fl_m;
  logic [5:0]     ch;
  logic [1:0]     tg;
  logic [3:0]     st;
  logic           err;
  logic           all_iso;
  int             n_mismatch;
  int             checks;
  int             n_blk;
  int             a;
  int             b;
  int             t;
  int             ev_tab[5] = '{16, 8, 4, 2, 32};
  int             fl_tab[5] = '{21, 22, 25, 31, 21};
  int             md_tab[3] = '{16, 48, 0};

  sblcf_regs u_sblcf_regs (
    .sys_clk             (sys_clk),
    .resetn              (resetn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .pstrb               (pstrb),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .link_ev             (link_ev),
    .iso_hdr             (iso_hdr),
    .rx_ev               (rx_ev),
    .iso_accept          (iso_accept),
    .receive_block_ready (receive_block_ready),
    .flush               (flush),
    .sizes               (sizes),
    .cycle_time          (cycle_time),
    .irq                 (irq)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (receive_block_ready === 1'b1)
      n_blk++;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd, input logic [3:0] sb);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    pstrb   <= sb;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd, 4'hF);
  endtask

  task automatic pulse(input sblcf_link_ev_t e);
    @(posedge sys_clk);
    link_ev <= e;
    @(posedge sys_clk);
    link_ev <= '0;
  endtask

  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    link_ev = '0;
    iso_hdr = '0;
    rx_ev = '0;
    iso_m = 32'h0;
    a = $urandom(45931);
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // Reset values and an unmapped read
    for (t = 8; t <= 28; t += 4)
    begin
      apb(1'b0, t[7:0], 32'h0, 4'h0);
      chk("reset_word", rd, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0, 4'h0);
    chk("unmapped_err", err, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    // Channel filter against random headers and byte strobes
    for (t = 0; t < 48; t++)
    begin
      if (t % 8 == 0)
      begin
        v = $urandom;
        st = 4'($urandom);
        apb(1'b1, `SBLCF_OFF_ISO, v, st);
        for (a = 0; a < 4; a++)
          if (st[a])
            iso_m[8*a+:8] = v[8*a+:8];
        apb(1'b0, `SBLCF_OFF_ISO, 32'h0, 4'h0);
        chk("iso_reg", rd, iso_m & `SBLCF_ISO_USED);
        all_iso = (t == 0) || ($urandom % 4 == 0);
        wr(`SBLCF_OFF_CTRL, {28'h0, all_iso, 3'h0});
      end
      ch = (t % 3 == 0) ? iso_m[7:2] :
           (t % 3 == 1) ? iso_m[15:10] : 6'($urandom);
      tg = 2'($urandom);
      @(posedge sys_clk);
      iso_hdr <= {1'b1, ch, tg};
      @(posedge sys_clk);
      iso_hdr <= '0;
      @(negedge sys_clk);
      chk("iso_accept", iso_accept, all_iso
        | (iso_m[16] && ch == iso_m[7:2] && (!iso_m[31] || tg == iso_m[1:0]))
        | (iso_m[17] && ch == iso_m[15:10]
           && (!iso_m[31] || tg == iso_m[9:8])));
    end
    // Queue sizing, trigger and flush pulses
    for (t = 0; t < 5; t++)
    begin
      a = (t == 0) ? 300 : $urandom % 512;
      b = (t == 0) ? 212 : $urandom % 512;
      v = {b[8:0], a[8:0], 9'(t + 2), 2'h0, 3'(t + 3)};
      wr(`SBLCF_OFF_QCTL, v);
      @(negedge sys_clk);
      chk("flush", flush, {v[0], v[1], v[2]});
      @(negedge sys_clk);
      chk("flush_clear", flush, 32'h0);
      chk("depths", {sizes.async_tx_queue_depth,
        sizes.iso_tx_queue_depth}, {a[8:0], b[8:0]});
      chk("rx_depth", sizes.rx_queue_depth,
        (a + b > 512) ? 0 : 512 - a - b);
      chk("trigger", sizes.trigger_size, t + 2);
      apb(1'b0, `SBLCF_OFF_QCTL, 32'h0, 4'h0);
      chk("qctl_reg", rd, v & 32'hFFFF_FFE0);
    end
    // Block-ready pulses with trigger 3 over a seven-quadlet packet
    wr(`SBLCF_OFF_QCTL, 32'h0000_0060);
    wr(`SBLCF_OFF_FLAGS, 32'hFFFF_FFFF);
    for (t = 0; t < 3; t++)
    begin
      wr(`SBLCF_OFF_CTRL, md_tab[t]);
      b = n_blk;
      for (a = 1; a <= 7; a++)
      begin
        @(posedge sys_clk);
        rx_ev <= {1'b1, a == 7};
      end
      @(posedge sys_clk);
      rx_ev <= '0;
      repeat (3) @(posedge sys_clk);
      chk("blocks", n_blk - b, (md_tab[t] == 16) ? 3 : 1);
    end
    apb(1'b0, `SBLCF_OFF_FLAGS, 32'h0, 4'h0);
    chk("rx_flag", rd[6], 32'h1);
    // Timer wrap through offset, cycle and seconds
    wr(`SBLCF_OFF_CTRL, 32'h0);
    wr(`SBLCF_OFF_FLAGS, 32'hFFFF_FFFF);
    wr(`SBLCF_OFF_TIMER, {12'hBFD, 13'h1F3F, 7'h7F});
    wr(`SBLCF_OFF_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk);
    wr(`SBLCF_OFF_CTRL, 32'h0);
    apb(1'b0, `SBLCF_OFF_TIMER, 32'h0, 4'h0);
    // Five enabled edges: offset BFD through the wrap to 002
    chk("timer", rd, 32'h0020_0000);
    chk("cycle_time", cycle_time, 32'h0020_0000);
    fl_m = 32'h0090_0000;
    apb(1'b0, `SBLCF_OFF_FLAGS, 32'h0, 4'h0);
    chk("flags_wrap", rd, fl_m);
    // Link events, mask and interrupt
    wr(`SBLCF_OFF_MASK, 32'h0200_0000);
    for (t = 0; t < 5; t++)
    begin
      pulse(6'(ev_tab[t]));
      fl_m[fl_tab[t]] = 1'b1;
      if (t == 1)
        fl_m[23] = 1'b0;
      apb(1'b0, `SBLCF_OFF_FLAGS, 32'h0, 4'h0);
      chk("flags_ev", rd, fl_m);
    end
    chk("irq_set", irq, 32'h1);
    wr(`SBLCF_OFF_FLAGS, 32'h0200_0000);
    fl_m[25] = 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("irq_clear", irq, 32'h0);
    apb(1'b0, `SBLCF_OFF_FLAGS, 32'h0, 4'h0);
    chk("flags_sticky", rd, fl_m);
    // Two rollovers without a received start, non-master then master
    for (t = 0; t < 2; t++)
    begin
      wr(`SBLCF_OFF_FLAGS, 32'hFFFF_FFFF);
      wr(`SBLCF_OFF_CTRL, (t == 0) ? 32'h5 : 32'h7);
      pulse(6'h01);
      pulse(6'h01);
      apb(1'b0, `SBLCF_OFF_FLAGS, 32'h0, 4'h0);
      chk("flags_lost", rd,
        (t == 0) ? 32'h0180_0000 : 32'h0080_0000);
    end
    tally_and_finish();
  end
endmodule // tb_sblcf_regs
